// [core/ppm_top.sv]
// ppm_top: port A/B/I/D/R pin logic with alternate-function muxing.
// assumes an Avalon-MM master on the core clock;
// peripherals supply alternate outputs and enables.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
module ppm_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  // port A
  input wire logic [15:0] port_a_in,
  output logic [15:0] port_a_out,
  output logic [15:0] port_a_oe_n_out,
  // port B
  input wire logic [15:0] port_b_in,
  output logic [15:0] port_b_out,
  output logic [15:0] port_b_oe_n_out,
  // port B alternate sources
  input wire logic uart_serial_out_in,
  input wire logic hdlc_one_closing_flag_in,
  input wire logic uart_clock_pin_in,
  input wire logic uart_clock_pin_oe_in,
  input wire logic timer_two_pin_in,
  input wire logic timer_two_pin_oe_in,
  input wire logic timer_three_pin_in,
  input wire logic timer_three_pin_oe_in,
  input wire logic serial_port_out_in,
  input wire logic serial_port_clock_in,
  input wire logic serial_port_clock_oe_in,
  input wire logic hold_grant_n_in,
  input wire logic [3:0] timer_sync_out_in,
  // port B alternate inputs seen by peripherals
  output logic uart_clock_pin_out,
  output logic timer_two_pin_out,
  output logic timer_three_pin_out,
  output logic serial_port_clock_out,
  // port I
  input wire logic [7:0] port_i_in,
  output logic hdlc_two_clock_out,
  output logic nmi_out,
  output logic ext_irq_2_out,
  output logic ext_irq_3_out,
  output logic ext_irq_4_or_wait_request_out,
  output logic serial_port_in_out,
  output logic uart_serial_in_out,
  output logic hdlc_one_clock_out,
  // port D
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe_n_out,
  input wire logic hdlc_one_transmit_out_in,
  input wire logic hdlc_one_transmit_oe_in,
  input wire logic hdlc_two_transmit_out_in,
  input wire logic hdlc_two_transmit_oe_in,
  output logic receiver_one_enable_or_frame_sync_out,
  output logic transmitter_one_enable_out,
  output logic receiver_two_enable_or_clock_out,
  output logic transmitter_two_enable_out,
  output logic hdlc_one_receive_in_out,
  output logic hdlc_two_receive_in_out,
  // port R
  input wire logic [7:0] port_r_in,
  output logic [7:0] port_r_out,
  output logic [7:0] port_r_oe_n_out
);
  logic [15:0] b_data_reg;
  logic [15:0] b_dir_reg;
  logic [15:0] port_b_function_select_reg;
  logic [15:0] b_pins_reg;
  logic [7:0] i_pins_reg;
  logic [7:0] d_pins_reg;
  logic [7:0] ctrl_reg;
  logic [15:0] xaddr_reg;
  logic [15:0] xdata_reg;
  logic go_pulse_reg;
  logic rd_seen_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic acc;
  logic wr_hit;
  logic [7:0] r_data;
  logic [7:0] r_dir;
  logic [7:0] r_pins;
  logic x_busy;
  logic [15:0] x_rdata;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic hbe_n;
  logic [15:0] alt_val;
  logic [15:0] alt_oe;
  logic [15:0] b_val;
  logic [15:0] b_oe;
  logic [3:0] bank;

  // byte-lane merge of a write
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus slave: one wait cycle then acknowledge
  assign acc = (avs_read_in | avs_write_in) & ~ack_reg;
  assign wr_hit = avs_write_in & ack_reg;
  assign avs_waitrequest_out = acc;
  assign avs_readdata_out = rdata_reg;
  assign avs_response_out = resp_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
    end else if (acc) begin
      resp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      case (avs_address_in)
        ppm_pkg::PPM_OFF_B_DATA: rdata_reg <= {16'h0, b_data_reg};
        ppm_pkg::PPM_OFF_B_DIR: rdata_reg <= {16'h0, b_dir_reg};
        ppm_pkg::PPM_OFF_B_FUNC: rdata_reg <= {16'h0, port_b_function_select_reg};
        ppm_pkg::PPM_OFF_B_PINS: rdata_reg <= {16'h0, b_pins_reg};
        ppm_pkg::PPM_OFF_I_PINS: rdata_reg <= {24'h0, i_pins_reg};
        ppm_pkg::PPM_OFF_D_PINS: rdata_reg <= {24'h0, d_pins_reg};
        ppm_pkg::PPM_OFF_R_DATA: rdata_reg <= {24'h0, r_data};
        ppm_pkg::PPM_OFF_R_DIR: rdata_reg <= {24'h0, r_dir};
        ppm_pkg::PPM_OFF_R_PINS: rdata_reg <= {24'h0, r_pins};
        ppm_pkg::PPM_OFF_CTRL: rdata_reg <= {24'h0, ctrl_reg};
        ppm_pkg::PPM_OFF_XADDR: rdata_reg <= {16'h0, xaddr_reg};
        ppm_pkg::PPM_OFF_XDATA: rdata_reg <= {16'h0, xdata_reg};
        ppm_pkg::PPM_OFF_XSTAT: rdata_reg <= {31'h0, x_busy};
        default: resp_reg <= 2'h2;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      b_data_reg <= ppm_pkg::PPM_RST_B_DATA;
      b_dir_reg <= ppm_pkg::PPM_RST_B_DIR;
      port_b_function_select_reg <= ppm_pkg::PPM_RST_B_FUNC;
    end else if (wr_hit) begin
      case (avs_address_in)
        ppm_pkg::PPM_OFF_B_DATA: b_data_reg <= merge16(b_data_reg, avs_writedata_in,
                                                        avs_byteenable_in);
        ppm_pkg::PPM_OFF_B_DIR: b_dir_reg <= merge16(b_dir_reg, avs_writedata_in,
                                                      avs_byteenable_in) &
                                              ppm_pkg::PPM_B_GEN_MASK;
        ppm_pkg::PPM_OFF_B_FUNC: port_b_function_select_reg <= merge16(
            port_b_function_select_reg, avs_writedata_in, avs_byteenable_in) &
            ppm_pkg::PPM_B_GEN_MASK;
        default: b_data_reg <= b_data_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= 8'h00;
      xaddr_reg <= 16'h0000;
      xdata_reg <= 16'h0000;
      go_pulse_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
    end else begin
      go_pulse_reg <= 1'b0;
      rd_seen_reg <= ~rd_n;
      if (wr_hit && avs_address_in == ppm_pkg::PPM_OFF_CTRL && avs_byteenable_in[0]) begin
        ctrl_reg <= avs_writedata_in[7:0];
      end
      if (wr_hit && avs_address_in == ppm_pkg::PPM_OFF_XADDR) begin
        xaddr_reg <= merge16(xaddr_reg, avs_writedata_in, avs_byteenable_in);
      end
      if (wr_hit && avs_address_in == ppm_pkg::PPM_OFF_XDATA) begin
        xdata_reg <= merge16(xdata_reg, avs_writedata_in, avs_byteenable_in);
      end else if (rd_seen_reg && rd_n) begin
        xdata_reg <= x_rdata;
      end
      if (wr_hit && avs_address_in == ppm_pkg::PPM_OFF_XSTAT && avs_byteenable_in[1]) begin
        go_pulse_reg <= avs_writedata_in[ppm_pkg::PPM_CTRL_GO] & ~x_busy;
      end
    end
  end

  // external bus cycle control bits ride in the status word write
  logic x_write_reg;
  logic x_byte_reg;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      x_write_reg <= 1'b0;
      x_byte_reg <= 1'b0;
    end else if (wr_hit && avs_address_in == ppm_pkg::PPM_OFF_XSTAT && avs_byteenable_in[1]) begin
      x_write_reg <= avs_writedata_in[ppm_pkg::PPM_CTRL_WRITE];
      x_byte_reg <= avs_writedata_in[ppm_pkg::PPM_CTRL_BYTE];
    end
  end

  // pin samples
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      b_pins_reg <= 16'h0000;
      i_pins_reg <= 8'h00;
      d_pins_reg <= 8'h00;
    end else begin
      b_pins_reg <= port_b_in;
      i_pins_reg <= port_i_in;
      d_pins_reg <= port_d_in;
    end
  end

  ppm_bus_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(go_pulse_reg),
    .write_in(x_write_reg),
    .byte_in(x_byte_reg),
    .addr_in(xaddr_reg),
    .wdata_in(xdata_reg),
    .busy_out(x_busy),
    .rdata_out(x_rdata),
    .a_pad_in(port_a_in),
    .a_pad_out(port_a_out),
    .a_pad_oe_n_out(port_a_oe_n_out),
    .ale_out(ale),
    .rd_n_out(rd_n),
    .wr_n_out(wr_n),
    .upper_byte_enable_n_out(hbe_n)
  );

  ppm_port_r u_port_r (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .data_wr_in(wr_hit && avs_address_in == ppm_pkg::PPM_OFF_R_DATA && avs_byteenable_in[0]),
    .dir_wr_in(wr_hit && avs_address_in == ppm_pkg::PPM_OFF_R_DIR && avs_byteenable_in[0]),
    .wdata_in(avs_writedata_in[7:0]),
    .data_out(r_data),
    .dir_out(r_dir),
    .pins_out(r_pins),
    .pad_in(port_r_in),
    .pad_out(port_r_out),
    .pad_oe_n_out(port_r_oe_n_out)
  );

  // alternate function drive
  assign bank = ctrl_reg[ppm_pkg::PPM_CTRL_BANK_LSB +: 4];
  always_comb begin
    alt_val = 16'h0000;
    alt_oe = 16'h0000;
    alt_val[0] = uart_serial_out_in;
    alt_oe[0] = 1'b1;
    alt_val[1] = hdlc_one_closing_flag_in;
    alt_oe[1] = 1'b1;
    alt_val[2] = uart_clock_pin_in;
    alt_oe[2] = uart_clock_pin_oe_in;
    alt_val[3] = timer_two_pin_in;
    alt_oe[3] = timer_two_pin_oe_in;
    alt_val[4] = timer_three_pin_in;
    alt_oe[4] = timer_three_pin_oe_in;
    alt_val[5] = serial_port_out_in;
    alt_oe[5] = 1'b1;
    alt_val[6] = serial_port_clock_in;
    alt_oe[6] = serial_port_clock_oe_in;
    alt_val[7] = hold_grant_n_in;
    alt_oe[7] = 1'b1;
    alt_val[9:8] = timer_sync_out_in[1:0];
    alt_oe[9:8] = 2'b11;
    alt_val[14:13] = timer_sync_out_in[3:2];
    alt_oe[14:13] = 2'b11;
    if (ctrl_reg[ppm_pkg::PPM_CTRL_EXT_BANK]) begin
      alt_val[9:8] = bank[1:0];
      alt_val[14:13] = bank[3:2];
    end
  end

  always_comb begin
    b_val = b_data_reg;
    b_oe = b_dir_reg;
    for (int k = 0; k < 16; k++) begin
      if (port_b_function_select_reg[k] ||
          (ctrl_reg[ppm_pkg::PPM_CTRL_EXT_BANK] && ppm_pkg::PPM_B_BANK_MASK[k])) begin
        b_val[k] = alt_val[k];
        b_oe[k] = alt_oe[k];
      end
    end
    b_val[ppm_pkg::PPM_B_ALE] = ale;
    b_val[ppm_pkg::PPM_B_WR] = wr_n;
    b_val[ppm_pkg::PPM_B_HBE] = hbe_n;
    b_val[ppm_pkg::PPM_B_RD] = rd_n;
    b_oe[ppm_pkg::PPM_B_ALE] = x_busy;
    b_oe[ppm_pkg::PPM_B_WR] = x_busy;
    b_oe[ppm_pkg::PPM_B_HBE] = 1'b1;
    b_oe[ppm_pkg::PPM_B_RD] = x_busy;
  end

  assign port_b_out = b_val;
  assign port_b_oe_n_out = ~b_oe;

  // alternate inputs from port B
  assign uart_clock_pin_out = b_pins_reg[2];
  assign timer_two_pin_out = b_pins_reg[3];
  assign timer_three_pin_out = b_pins_reg[4];
  assign serial_port_clock_out = b_pins_reg[6];

  // port I peripheral inputs
  assign hdlc_two_clock_out = i_pins_reg[0];
  assign nmi_out = i_pins_reg[1];
  assign ext_irq_2_out = i_pins_reg[2];
  assign ext_irq_3_out = i_pins_reg[3];
  assign ext_irq_4_or_wait_request_out = i_pins_reg[4];
  assign serial_port_in_out = i_pins_reg[5];
  assign uart_serial_in_out = i_pins_reg[6];
  assign hdlc_one_clock_out = i_pins_reg[7];

  // port D peripheral pins
  assign receiver_one_enable_or_frame_sync_out = d_pins_reg[0];
  assign transmitter_one_enable_out = d_pins_reg[1];
  assign receiver_two_enable_or_clock_out = d_pins_reg[2];
  assign transmitter_two_enable_out = d_pins_reg[3];
  assign hdlc_one_receive_in_out = d_pins_reg[4];
  assign hdlc_two_receive_in_out = d_pins_reg[6];
  always_comb begin
    port_d_out = 8'h00;
    port_d_oe_n_out = 8'hFF;
    port_d_out[5] = hdlc_one_transmit_out_in;
    port_d_out[7] = hdlc_two_transmit_out_in;
    port_d_oe_n_out[5] = ~(rst_n_in & hdlc_one_transmit_oe_in);
    port_d_oe_n_out[7] = ~(rst_n_in & hdlc_two_transmit_oe_in);
  end
endmodule

// [core/ppm_pkg.sv]
// ppm_pkg: register map and constants of the port/pin block.
// assumes an Avalon-MM slave with 32-bit data, word-aligned registers.
//
// Behaviour
// - Port A time-multiplexes address and data for external memory.
// - An address latch strobe marks the address phase for outside latching.
// - External reads use an active-low read strobe and writes a separate active-low store strobe.
// - Byte or word access is decoded outside from the upper-byte enable and bus bit zero.
// - Port B is 16 bits with 12 general pins; B10, B11, B12 and B15 are bus control outputs.
// - The function register switches each general port B pin to I/O or alternate use.
// - Port B alternate uses are UART, closing flag, timers, serial port, hold grant and sync outs.
// - In extended addressing mode B8, B9, B13, B14 carry bank select bits 0 to 3, B8 least significant.
// - Port I is an 8-bit input port readable as general inputs that also feeds peripheral inputs.
// - Port D carries the HDLC enables, clocks, receive inputs and transmit outputs; D0 takes frame sync.
// - Every input pin level can be read by software at any time; port A is only sampled into XDATA at the end of an external read.
// - Port R is 8 bits bidirectional with a per-pin direction register.
// - Port R has a data register whose bits are driven on output pins.
// - Reading the port R pin address returns the real pin levels.
// - After reset ports A, B except B12, D and R are high impedance.
package ppm_pkg;
  // register byte offsets
  localparam logic [5:0] PPM_OFF_B_DATA = 6'h00;
  localparam logic [5:0] PPM_OFF_B_DIR = 6'h04;
  localparam logic [5:0] PPM_OFF_B_FUNC = 6'h08;
  localparam logic [5:0] PPM_OFF_B_PINS = 6'h0C;
  localparam logic [5:0] PPM_OFF_I_PINS = 6'h10;
  localparam logic [5:0] PPM_OFF_D_PINS = 6'h14;
  localparam logic [5:0] PPM_OFF_R_DATA = 6'h18;
  localparam logic [5:0] PPM_OFF_R_DIR = 6'h1C;
  localparam logic [5:0] PPM_OFF_R_PINS = 6'h20;
  localparam logic [5:0] PPM_OFF_CTRL = 6'h24;
  localparam logic [5:0] PPM_OFF_XADDR = 6'h28;
  localparam logic [5:0] PPM_OFF_XDATA = 6'h2C;
  localparam logic [5:0] PPM_OFF_XSTAT = 6'h30;
  // control register fields, then external cycle bits of the status word write
  localparam int PPM_CTRL_EXT_BANK = 0;
  localparam int PPM_CTRL_BANK_LSB = 4;
  localparam int PPM_CTRL_BYTE = 8;
  localparam int PPM_CTRL_WRITE = 9;
  localparam int PPM_CTRL_GO = 10;
  // port B bit positions
  localparam int PPM_B_ALE = 10;
  localparam int PPM_B_WR = 11;
  localparam int PPM_B_HBE = 12;
  localparam int PPM_B_RD = 15;
  // general (non bus control) pins
  localparam logic [15:0] PPM_B_GEN_MASK = 16'h63FF;
  // bank bits sit on B8,B9,B13,B14
  localparam logic [15:0] PPM_B_BANK_MASK = 16'h6300;
  // reset values
  localparam logic [15:0] PPM_RST_B_DATA = 16'h0000;
  localparam logic [15:0] PPM_RST_B_DIR = 16'h0000;
  localparam logic [15:0] PPM_RST_B_FUNC = 16'h0000;
  localparam logic [7:0] PPM_RST_R_DATA = 8'h00;
  localparam logic [7:0] PPM_RST_R_DIR = 8'h00;
  // phase length in clocks
  localparam logic [1:0] PPM_PHASE_CYC = 2'h2;
  typedef enum logic [2:0] {
    PPM_X_IDLE = 3'b000,
    PPM_X_ADDR = 3'b001,
    PPM_X_HOLD = 3'b010,
    PPM_X_STRB = 3'b011,
    PPM_X_DONE = 3'b100
  } ppm_xstate_t;
endpackage

// [core/ppm_port_r.sv]
// ppm_port_r: general 8-bit bidirectional port with data and direction.
// assumes register writes arrive as one-cycle strobes from the bus slave.
module ppm_port_r (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register side
  input wire logic data_wr_in,
  input wire logic dir_wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] data_out,
  output logic [7:0] dir_out,
  output logic [7:0] pins_out,
  // pins
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n_out
);
  logic [7:0] data_reg;
  logic [7:0] dir_reg;
  logic [7:0] pins_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      data_reg <= ppm_pkg::PPM_RST_R_DATA;
    end else if (data_wr_in) begin
      data_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dir_reg <= ppm_pkg::PPM_RST_R_DIR;
    end else if (dir_wr_in) begin
      dir_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pins_reg <= 8'h00;
    end else begin
      pins_reg <= pad_in;
    end
  end

  assign data_out = data_reg;
  assign dir_out = dir_reg;
  assign pins_out = pins_reg;
  assign pad_out = data_reg;
  assign pad_oe_n_out = ~dir_reg;
endmodule

// [core/ppm_bus_seq.sv]
// ppm_bus_seq: multiplexed external bus cycle sequencer for port A.
// assumes one request at a time; start pulses while busy are ignored.
module ppm_bus_seq (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // request
  input wire logic start_in,
  input wire logic write_in,
  input wire logic byte_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic busy_out,
  output logic [15:0] rdata_out,
  // port A pins
  input wire logic [15:0] a_pad_in,
  output logic [15:0] a_pad_out,
  output logic [15:0] a_pad_oe_n_out,
  // bus control
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic upper_byte_enable_n_out
);
  ppm_pkg::ppm_xstate_t state_reg;
  logic [1:0] cnt_reg;
  logic wr_reg;
  logic [15:0] a_reg;
  logic a_oe_n_reg;
  logic [15:0] rdata_reg;
  logic hbe_n_reg;

  // word access or odd byte enables the high lane
  function automatic logic hbe_n_of(input logic is_byte, input logic bit0);
    hbe_n_of = is_byte & ~bit0;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg <= ppm_pkg::PPM_X_IDLE;
      cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ppm_pkg::PPM_X_IDLE: begin
          if (start_in) begin
            state_reg <= ppm_pkg::PPM_X_ADDR;
            cnt_reg <= ppm_pkg::PPM_PHASE_CYC - 2'h1;
          end
        end
        ppm_pkg::PPM_X_ADDR: begin
          if (cnt_reg == 2'h0) begin
            state_reg <= ppm_pkg::PPM_X_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        ppm_pkg::PPM_X_HOLD: begin
          state_reg <= ppm_pkg::PPM_X_STRB;
          cnt_reg <= ppm_pkg::PPM_PHASE_CYC - 2'h1;
        end
        ppm_pkg::PPM_X_STRB: begin
          if (cnt_reg == 2'h0) begin
            state_reg <= ppm_pkg::PPM_X_DONE;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        ppm_pkg::PPM_X_DONE: state_reg <= ppm_pkg::PPM_X_IDLE;
        default: state_reg <= ppm_pkg::PPM_X_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_reg <= 1'b0;
      a_reg <= 16'h0000;
      a_oe_n_reg <= 1'b1;
      hbe_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        ppm_pkg::PPM_X_IDLE: begin
          a_oe_n_reg <= 1'b1;
          hbe_n_reg <= 1'b1;
          if (start_in) begin
            wr_reg <= write_in;
            a_reg <= addr_in;
            a_oe_n_reg <= 1'b0;
            hbe_n_reg <= hbe_n_of(byte_in, addr_in[0]);
          end
        end
        ppm_pkg::PPM_X_HOLD: begin
          a_reg <= wdata_in;
          a_oe_n_reg <= ~wr_reg;
        end
        ppm_pkg::PPM_X_DONE: begin
          a_oe_n_reg <= 1'b1;
          hbe_n_reg <= 1'b1;
        end
        default: a_oe_n_reg <= a_oe_n_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 16'h0000;
    end else if (state_reg == ppm_pkg::PPM_X_STRB && cnt_reg == 2'h0 && !wr_reg) begin
      rdata_reg <= a_pad_in;
    end
  end

  assign busy_out = (state_reg != ppm_pkg::PPM_X_IDLE);
  assign rdata_out = rdata_reg;
  assign a_pad_out = a_reg;
  assign a_pad_oe_n_out = {16{a_oe_n_reg}};
  assign ale_out = (state_reg == ppm_pkg::PPM_X_ADDR);
  assign rd_n_out = ~(state_reg == ppm_pkg::PPM_X_STRB && !wr_reg);
  assign wr_n_out = ~(state_reg == ppm_pkg::PPM_X_STRB && wr_reg);
  assign upper_byte_enable_n_out = hbe_n_reg;
endmodule

// [dv/ppm_top_props.sv]
// ppm_top_props: pin and bus strobe timing.
// assumes it is bound to ppm_top and sees only its ports.
module ppm_top_props (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register bus
  input wire logic [5:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // pins
  input wire logic [15:0] port_a_oe_n_out,
  input wire logic [15:0] port_b_out,
  input wire logic [15:0] port_b_oe_n_out,
  input wire logic [7:0] port_d_oe_n_out,
  input wire logic [7:0] port_r_out,
  input wire logic [7:0] port_r_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire ale = port_b_out[10] & ~port_b_oe_n_out[10];
  wire rd = ~port_b_out[15] & ~port_b_oe_n_out[15];
  wire wr = ~port_b_out[11] & ~port_b_oe_n_out[11];
  wire acc = avs_write_in & ~avs_waitrequest_out;
  reset_float_a:
    assert property ($rose(rst_n_in) |-> &port_a_oe_n_out && &port_r_oe_n_out &&
      &port_d_oe_n_out && port_b_oe_n_out == 16'hEFFF) else $error("pins driven after reset");
  r_dir_cause_a:
    assert property (!$stable(port_r_oe_n_out) |-> $past(acc &&
      avs_address_in == ppm_pkg::PPM_OFF_R_DIR) &&
      port_r_oe_n_out == ~$past(avs_writedata_in[7:0])) else $error("bad r direction");
  r_data_cause_a:
    assert property (!$stable(port_r_out) |-> $past(acc &&
      avs_address_in == ppm_pkg::PPM_OFF_R_DATA) &&
      port_r_out == $past(avs_writedata_in[7:0])) else $error("bad r data");
  ale_width_a:
    assert property ($rose(ale) |=> ale ##1 !ale) else $error("latch strobe width");
  ale_addr_a:
    assert property (ale |-> port_a_oe_n_out == 16'h0000 && !rd && !wr)
      else $error("address phase wrong");
  ale_strobe_a:
    assert property ($fell(ale) |-> ##[1:3] (rd || wr)) else $error("no strobe after latch");
  rd_width_a:
    assert property ($rose(rd) |=> rd ##1 !rd) else $error("read strobe width");
  wr_width_a:
    assert property ($rose(wr) |=> wr ##1 !wr) else $error("write strobe width");
  rd_float_a:
    assert property (rd |-> &port_a_oe_n_out) else $error("bus driven during read");
  d_inputs_a:
    assert property ({port_d_oe_n_out[6], port_d_oe_n_out[4:0]} == 6'h3F)
      else $error("port d input driven");
endmodule
bind ppm_top ppm_top_props u_props (.*);

// [dv/ppm_mem_model.sv]
// ppm_mem_model: external word memory on the multiplexed port A bus.
// assumes the bus strobes on port B.
module ppm_mem_model (
  input wire logic clk_sys_in,
  input wire logic [15:0] port_a_out,
  input wire logic [15:0] port_a_oe_n_out,
  input wire logic [15:0] port_b_out,
  input wire logic [15:0] port_b_oe_n_out,
  output logic [15:0] port_a_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] adr = '0;
  logic [15:0] last = '0;
  wire ale = port_b_out[10] & ~port_b_oe_n_out[10];
  wire rd = ~port_b_out[15] & ~port_b_oe_n_out[15];
  wire wr = ~port_b_out[11] & ~port_b_oe_n_out[11];
  // released lines show a changing pattern
  assign port_a_in = (~port_a_oe_n_out & port_a_out) |
    (port_a_oe_n_out & (rd ? mem[adr[8:1]] : ~last));
  always @(posedge clk_sys_in) begin
    last <= port_a_in;
    if (ale) adr <= port_a_out;
    if (wr && !adr[0]) mem[adr[8:1]][7:0] <= port_a_out[7:0];
    if (wr && !port_b_out[12]) mem[adr[8:1]][15:8] <= port_a_out[15:8];
  end
endmodule

// [dv/port_pin_function_mux_test.sv]
// port_pin_function_mux_test: register tests of the port/pin block.
// assumes the memory model on port A and a 40 MHz core clock.
module port_pin_function_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, alt = 0, dtx = 0;
  logic [5:0] avs_address_in = '0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = '0, rdat;
  logic [1:0] rsp;
  logic [15:0] b_ext = '0;
  logic [7:0] port_i_in = 8'h96, r_ext = 8'h3C, d_ext = 8'h5A;
  wire [31:0] avs_readdata_out;
  wire [1:0] avs_response_out;
  wire [15:0] port_a_in, port_a_out, port_a_oe_n_out, port_b_in, port_b_out, port_b_oe_n_out;
  wire [7:0] port_r_in, port_r_out, port_r_oe_n_out, port_d_in, port_d_out, port_d_oe_n_out;
  wire avs_waitrequest_out, uart_clock_pin_out, timer_two_pin_out, timer_three_pin_out;
  wire serial_port_clock_out, hdlc_two_clock_out, nmi_out, ext_irq_2_out, ext_irq_3_out;
  wire ext_irq_4_or_wait_request_out, serial_port_in_out, uart_serial_in_out, hdlc_one_clock_out;
  wire receiver_one_enable_or_frame_sync_out, transmitter_one_enable_out;
  wire receiver_two_enable_or_clock_out, transmitter_two_enable_out;
  wire hdlc_one_receive_in_out, hdlc_two_receive_in_out;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  assign port_r_in = (~port_r_oe_n_out & port_r_out) | (port_r_oe_n_out & r_ext);
  assign port_b_in = (~port_b_oe_n_out & port_b_out) | (port_b_oe_n_out & b_ext);
  assign port_d_in = (~port_d_oe_n_out & port_d_out) | (port_d_oe_n_out & d_ext);
  ppm_top dut (.*, .uart_serial_out_in(alt), .hdlc_one_closing_flag_in(alt),
    .uart_clock_pin_in(alt), .uart_clock_pin_oe_in(1'b0), .timer_two_pin_in(alt),
    .timer_two_pin_oe_in(1'b0), .timer_three_pin_in(alt), .timer_three_pin_oe_in(1'b0),
    .serial_port_out_in(alt), .serial_port_clock_in(alt), .serial_port_clock_oe_in(1'b0),
    .hold_grant_n_in(alt), .timer_sync_out_in({4{alt}}), .hdlc_one_transmit_out_in(dtx),
    .hdlc_one_transmit_oe_in(dtx), .hdlc_two_transmit_out_in(dtx), .hdlc_two_transmit_oe_in(dtx));
  ppm_mem_model mem (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    rdat = avs_readdata_out;
    rsp = avs_response_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rdat, e);
  endtask
  task automatic xfer(input logic [31:0] d, input logic [31:0] c);
    bus(1, ppm_pkg::PPM_OFF_XDATA, d);
    bus(1, ppm_pkg::PPM_OFF_XSTAT, c);
    do bus(0, ppm_pkg::PPM_OFF_XSTAT, 0); while (rdat[0] !== 1'b0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    if (++cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1;
    @(posedge clk_sys_in);
    chk({port_a_oe_n_out, port_b_oe_n_out}, 32'hFFFFEFFF);
    chk({port_r_oe_n_out, port_d_oe_n_out}, 16'hFFFF);
    rd(6'h3C, 0);
    chk(rsp, 2'h2);
    bus(1, ppm_pkg::PPM_OFF_R_DIR, 32'h0F);
    bus(1, ppm_pkg::PPM_OFF_R_DATA, 32'hA5);
    rd(ppm_pkg::PPM_OFF_R_PINS, 32'h35);
    rd(ppm_pkg::PPM_OFF_R_DATA, 32'hA5);
    chk({port_r_oe_n_out, port_r_out}, 16'hF0A5);
    rd(ppm_pkg::PPM_OFF_I_PINS, 32'h96);
    chk({hdlc_one_clock_out, uart_serial_in_out, serial_port_in_out,
      ext_irq_4_or_wait_request_out, ext_irq_3_out, ext_irq_2_out, nmi_out, hdlc_two_clock_out},
      8'h96);
    chk({hdlc_two_receive_in_out, hdlc_one_receive_in_out, transmitter_two_enable_out,
      receiver_two_enable_or_clock_out, transmitter_one_enable_out,
      receiver_one_enable_or_frame_sync_out}, 6'h3A);
    dtx <= 1;
    rd(ppm_pkg::PPM_OFF_D_PINS, 32'hFA);
    bus(1, ppm_pkg::PPM_OFF_B_FUNC, 32'h63A3);
    for (int v = 0; v < 2; v++) begin
      alt <= v[0];
      b_ext <= v ? 16'h005C : 16'h0000;
      repeat (2) @(posedge clk_sys_in);
      chk({port_b_oe_n_out & 16'h63A3, port_b_out & 16'h63A3}, v ? 16'h63A3 : 0);
      chk({serial_port_clock_out, timer_three_pin_out, timer_two_pin_out,
        uart_clock_pin_out}, {4{v[0]}});
    end
    bus(1, ppm_pkg::PPM_OFF_B_FUNC, 0);
    bus(1, ppm_pkg::PPM_OFF_CTRL, 32'h91);
    @(posedge clk_sys_in);
    chk({port_b_oe_n_out & 16'h6300, port_b_out & 16'h6300}, 32'h4100);
    bus(1, ppm_pkg::PPM_OFF_XADDR, 32'h1234);
    xfer(32'hBEEF, 32'h0600);
    xfer(0, 32'h0400);
    rd(ppm_pkg::PPM_OFF_XDATA, 32'hBEEF);
    xfer(32'h0011, 32'h0700);
    xfer(0, 32'h0400);
    rd(ppm_pkg::PPM_OFF_XDATA, 32'hBE11);
    bus(1, ppm_pkg::PPM_OFF_B_DIR, 32'hFFFF);
    rd(ppm_pkg::PPM_OFF_B_DIR, 32'h63FF);
    complete_run();
  end
endmodule
